// ==== design/serial_audio_pkg.sv ====
package serial_audio_pkg;

  // Register offsets on the control port
  localparam logic [6:0] CTRL1_OFS       = 7'h01;
  localparam logic [6:0] FORMAT_OFS      = 7'h03;
  localparam logic [6:0] INT1_STATUS_OFS = 7'h0d;
  localparam logic [6:0] STRAP_OFS       = 7'h0e;
  localparam logic [6:0] ID_OFS          = 7'h7f;

  // Control register 1 fields
  localparam int MUTE_BIT  = 0;
  localparam int RUN_BIT   = 1;
  localparam int ROUTE_BIT = 2;
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] FORMAT_RST = 8'h00;

  // Status fields
  localparam int SLIP_BIT     = 5;
  localparam int STRAP_ADDR   = 0;
  localparam int STRAP_HWMODE = 1;
  localparam int STRAP_RUN    = 2;

  // Resolution encodings and their word lengths
  localparam logic [1:0] RES_24  = 2'b00;
  localparam logic [1:0] RES_20  = 2'b01;
  localparam logic [1:0] RES_16  = 2'b10;
  localparam logic [1:0] RES_AES = 2'b11;
  localparam logic [5:0] LEN_24  = 6'd24;
  localparam logic [5:0] LEN_20  = 6'd20;
  localparam logic [5:0] LEN_16  = 6'd16;
  localparam logic [5:0] LEN_AES = 6'd28;

  // Timing, clk runs at 256 Fs
  localparam int         CLK_PERIOD_PS   = 4000;
  localparam logic [2:0] EVAL_DELAY_CYC  = 3'd4;
  localparam logic [6:0] HALF_BITS_LO    = 7'd32;
  localparam logic [6:0] HALF_BITS_HI    = 7'd64;
  localparam logic [7:0] BLK_START_FIRST = 8'd2;
  localparam logic [7:0] BLK_START_LEN   = 8'd16;

  typedef struct packed {
    logic        portMasterSelect;
    logic        bitClockRateSelect;
    logic [1:0]  wordResolutionSelect;
    logic        justifySelect;
    logic        firstBitDelay;
    logic        bitClockPolarity;
    logic        frameClockPolarity;
  } out_format_t;

  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
    logic [2:0]  vucLeft;
    logic [2:0]  vucRight;
    logic        blockZ;
  } audio_frame_t;

  typedef enum logic [2:0] {ST_STRAP, ST_IDLE, ST_LOCK, ST_RUN} run_state_t;

endpackage

// ==== design/pin_sync.sv ====
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // No reset: pins must keep flowing while reset is held for strap capture
  always_ff @(posedge clk) begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule

// ==== design/audio_fifo.sv ====
module audio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("audio_fifo DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign push      = inValid && inReady;
  assign pop       = outValid && outReady;
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign outValid  = count_r != '0;
  assign outData   = mem[rdPtr_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      inReady <= 1'b0;
    end else begin
      wrPtr_r <= wrPtr_r + AW'(push);
      rdPtr_r <= rdPtr_r + AW'(pop);
      count_r <= count_nxt;
      inReady <= count_nxt != (AW+1)'(DEPTH);
    end
  end
endmodule

// ==== design/serial_audio_output_port.sv ====
module serial_audio_output_port
  import serial_audio_pkg::*;
#(
  parameter int         FIFO_DEPTH = 32,
  parameter logic [3:0] PART_ID    = 4'h5,  // Arbitrary value
  parameter logic [3:0] REVISION   = 4'h1   // Arbitrary value
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         pllLocked,
  input  wire logic         preambleZ,
  input  wire logic         preambleX,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire audio_frame_t inFrame,
  input  wire logic [6:0]   regAddr,
  input  wire logic         regWrEn,
  input  wire logic [7:0]   regWrData,
  input  wire logic         regRdEn,
  output logic      [7:0]   regRdData,
  input  wire logic         outputFrameClockIn,
  output logic              outputFrameClockOut,
  output logic              outputFrameClockOe,
  input  wire logic         outputBitClockIn,
  output logic              outputBitClockOut,
  output logic              outputBitClockOe,
  input  wire logic         serialDataOutSense,
  output logic              serialDataOut,
  output logic              serialDataOutOe,
  input  wire logic         generalOutTwoSense,
  output logic              generalOutTwo,
  output logic              generalOutTwoOe,
  output logic              blockStartOut,
  output logic              hardwareMode,
  output logic              addrStrapBit
);
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("FIFO_DEPTH too small");
  end

  // Synchronised pins
  logic [3:0]   pinSync;
  logic         fcSync;
  logic         bcSync;
  logic         sdSense;
  logic         gpSense;

  // Registers and state
  out_format_t  fmt_r;
  logic [7:0]   ctrl1_r;
  logic         slip_r;
  logic         slip_nxt;
  run_state_t   state_r;
  run_state_t   state_nxt;
  logic         enabled_r;
  logic [7:0]   frameCnt_r;
  logic         fcPrev_r;
  logic         bcPrev_r;
  logic [6:0]   slaveBit_r;
  audio_frame_t hold_r;
  logic         holdValid_r;
  logic [2:0]   evalCnt_r;
  logic [1:0]   edgeCnt_r;
  logic         holdoff_r;
  logic         primed_r;
  logic [7:0]   blkCnt_r;
  logic         blkSeen_r;

  // Decoded terms
  logic         isMaster;
  logic         muteOn;
  logic         rjEff;
  logic         fcEdge;
  logic         activeEdge;
  logic         shiftEdge;
  logic         popNow;
  logic         fifoValid;
  audio_frame_t fifoData;
  audio_frame_t cur;
  logic         halfM;
  logic         fcM;
  logic         bcM;
  logic [6:0]   bitIdxM;
  logic [6:0]   bitIdx;
  logic         halfSel;
  logic [6:0]   halfBits;
  logic [23:0]  sample;
  logic [2:0]   vuc;
  logic [31:0]  word;
  logic [5:0]   resBits;
  logic         dataBit;
  logic         evalNow;
  logic         slipEvent;
  logic         slipSet;
  logic         rdClear;
  logic         blkNxt;
  logic [7:0]   rdMux;

  pin_sync #(.W(4)) u_sync (
    .clk (clk),
    .d   ({outputFrameClockIn, outputBitClockIn, serialDataOutSense, generalOutTwoSense}),
    .q   (pinSync)
  );
  assign {fcSync, bcSync, sdSense, gpSense} = pinSync;

  audio_fifo #(.WIDTH($bits(audio_frame_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (inValid),
    .inReady  (inReady),
    .inData   (inFrame),
    .outValid (fifoValid),
    .outReady (popNow),
    .outData  (fifoData)
  );

  // Bit picker, left or right aligned within one half frame
  function automatic logic pick_bit(input logic [31:0] w, input logic [5:0] len,
                                    input logic [6:0] k, input logic [6:0] hb,
                                    input logic rj, input logic dly);
    logic [6:0] pos;
    logic [6:0] j;
    logic [6:0] idx;
    logic       b;
    pos = 7'(k - 7'(dly));
    j   = 7'(hb - 7'd1 - k);
    idx = 7'(7'd32 - 7'(len) + j);
    b   = 1'b0;
    if (rj) begin
      if (k < hb && j < 7'(len)) begin
        b = w[idx[4:0]];
      end
    end else if (k >= 7'(dly) && pos < 7'(len)) begin
      b = w[5'(7'd31 - pos)];
    end
    return b;
  endfunction

  // Run and strap sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STRAP: state_nxt = ST_IDLE;
      ST_IDLE:  if (ctrl1_r[RUN_BIT]) state_nxt = ST_LOCK;
      ST_LOCK: begin
        if (!ctrl1_r[RUN_BIT]) state_nxt = ST_IDLE;
        else if (pllLocked) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (!ctrl1_r[RUN_BIT]) state_nxt = ST_IDLE;
        else if (!pllLocked) state_nxt = ST_LOCK;
      end
      default:  state_nxt = ST_STRAP;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r   <= ST_STRAP;
      enabled_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      enabled_r <= state_nxt == ST_RUN;
    end
  end

  // Straps are read one cycle after release, from pins that were inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hardwareMode <= 1'b0;
      addrStrapBit <= 1'b0;
    end else if (state_r == ST_STRAP) begin
      hardwareMode <= !sdSense;
      addrStrapBit <= gpSense;
    end
  end

  // Register port
  assign rdClear = regRdEn && regAddr == INT1_STATUS_OFS;
  assign rdMux   = (regAddr == CTRL1_OFS)       ? ctrl1_r :
                   (regAddr == FORMAT_OFS)      ? fmt_r :
                   (regAddr == INT1_STATUS_OFS) ? 8'(slip_r) << SLIP_BIT :
                   (regAddr == STRAP_OFS)       ? {5'h00, enabled_r, hardwareMode,
                                                   addrStrapBit} :
                   (regAddr == ID_OFS)          ? {PART_ID, REVISION} :
                   8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl1_r   <= CTRL1_RST;
      fmt_r     <= FORMAT_RST;
      regRdData <= 8'h00;
    end else begin
      if (regWrEn && regAddr == CTRL1_OFS) ctrl1_r <= regWrData;
      if (regWrEn && regAddr == FORMAT_OFS) fmt_r <= regWrData;
      regRdData <= regRdEn ? rdMux : 8'h00;
    end
  end

  // Master timing from the 256 Fs count
  assign isMaster = fmt_r.portMasterSelect;
  assign muteOn   = ctrl1_r[MUTE_BIT] || !enabled_r;
  assign rjEff    = fmt_r.justifySelect && isMaster;
  assign halfM    = frameCnt_r[7];
  assign fcM      = halfM ^ !fmt_r.frameClockPolarity;
  assign bcM      = fmt_r.bitClockRateSelect ? frameCnt_r[0] : frameCnt_r[1];
  assign bitIdxM  = fmt_r.bitClockRateSelect ? {1'b0, frameCnt_r[6:1]}
                                             : {2'b00, frameCnt_r[6:2]};

  // Slave edges, only on synchronised copies
  assign fcEdge     = fcSync != fcPrev_r;
  assign activeEdge = fcEdge && fcSync == !fmt_r.frameClockPolarity;
  assign shiftEdge  = bcSync != bcPrev_r && bcSync == fmt_r.bitClockPolarity;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frameCnt_r <= 8'h00;
      fcPrev_r   <= 1'b0;
      bcPrev_r   <= 1'b0;
      slaveBit_r <= 7'd0;
    end else begin
      frameCnt_r <= (enabled_r && isMaster) ? frameCnt_r + 8'd1 : 8'h00;
      fcPrev_r   <= fcSync;
      bcPrev_r   <= bcSync;
      if (fcEdge) slaveBit_r <= 7'd0;
      else if (shiftEdge && slaveBit_r != 7'h7f) slaveBit_r <= slaveBit_r + 7'd1;
    end
  end

  // Frame buffer; an empty FIFO repeats the previous frame
  assign popNow = enabled_r && (isMaster ? frameCnt_r == 8'h00 : activeEdge);
  assign cur    = (popNow && fifoValid) ? fifoData : hold_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_r      <= '0;
      holdValid_r <= 1'b0;
    end else if (popNow && fifoValid) begin
      hold_r      <= fifoData;
      holdValid_r <= 1'b1;
    end
  end

  // Word assembly
  assign bitIdx   = isMaster ? bitIdxM : slaveBit_r;
  assign halfSel  = isMaster ? halfM : fcSync == fmt_r.frameClockPolarity;
  assign halfBits = fmt_r.bitClockRateSelect ? HALF_BITS_HI : HALF_BITS_LO;
  assign sample   = halfSel ? cur.right : cur.left;
  assign vuc      = halfSel ? cur.vucRight : cur.vucLeft;
  assign word     = (fmt_r.wordResolutionSelect == RES_24) ? {sample, 8'h00} :
                    (fmt_r.wordResolutionSelect == RES_20) ? {sample[23:4], 12'h000} :
                    (fmt_r.wordResolutionSelect == RES_16) ? {sample[23:8], 16'h0000} :
                    {sample, vuc, cur.blockZ && !halfSel, 4'h0};
  assign resBits  = (fmt_r.wordResolutionSelect == RES_24) ? LEN_24 :
                    (fmt_r.wordResolutionSelect == RES_20) ? LEN_20 :
                    (fmt_r.wordResolutionSelect == RES_16) ? LEN_16 : LEN_AES;
  assign dataBit  = pick_bit(word, resBits, bitIdx, halfBits, rjEff, fmt_r.firstBitDelay);

  // Pin drivers; enables stay low until straps are captured
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outputFrameClockOut <= 1'b0;
      outputFrameClockOe  <= 1'b0;
      outputBitClockOut   <= 1'b0;
      outputBitClockOe    <= 1'b0;
      serialDataOut       <= 1'b0;
      serialDataOutOe     <= 1'b0;
      generalOutTwo       <= 1'b0;
      generalOutTwoOe     <= 1'b0;
    end else begin
      outputFrameClockOut <= enabled_r && isMaster && fcM;
      outputFrameClockOe  <= enabled_r && isMaster;
      outputBitClockOut   <= enabled_r && isMaster && (bcM ^ fmt_r.bitClockPolarity);
      outputBitClockOe    <= enabled_r && isMaster;
      serialDataOut       <= !muteOn && holdValid_r && dataBit;
      serialDataOutOe     <= state_r != ST_STRAP;
      generalOutTwo       <= ctrl1_r[ROUTE_BIT] && blkNxt;
      generalOutTwoOe     <= state_r != ST_STRAP;
    end
  end

  // Slip and repeat check, a few cycles after each Z or X preamble
  assign evalNow   = evalCnt_r == 3'd1;
  assign slipEvent = edgeCnt_r != 2'd1;
  // One suppressed evaluation after an event absorbs jitter at the crossing
  assign slipSet   = evalNow && enabled_r && !isMaster && primed_r && slipEvent
                     && !holdoff_r;
  assign slip_nxt  = slipSet || (slip_r && !rdClear);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      evalCnt_r <= 3'd0;
      edgeCnt_r <= 2'd0;
      holdoff_r <= 1'b0;
      primed_r  <= 1'b0;
      slip_r    <= 1'b0;
    end else begin
      if (preambleZ || preambleX) evalCnt_r <= EVAL_DELAY_CYC;
      else if (evalCnt_r != 3'd0) evalCnt_r <= evalCnt_r - 3'd1;
      if (evalNow) edgeCnt_r <= {1'b0, activeEdge};
      else if (activeEdge && edgeCnt_r != 2'd3) edgeCnt_r <= edgeCnt_r + 2'd1;
      if (evalNow) holdoff_r <= slipEvent && !holdoff_r;
      if (evalNow) primed_r <= enabled_r && !isMaster;
      slip_r <= slip_nxt;
    end
  end

  // Block start, counted in received frames since the Z preamble
  assign blkNxt = blkSeen_r && blkCnt_r >= BLK_START_FIRST
                  && blkCnt_r < BLK_START_FIRST + BLK_START_LEN;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blkCnt_r      <= 8'h00;
      blkSeen_r     <= 1'b0;
      blockStartOut <= 1'b0;
    end else begin
      if (preambleZ) begin
        blkCnt_r  <= 8'h00;
        blkSeen_r <= 1'b1;
      end else if (preambleX && blkCnt_r != 8'hff) begin
        blkCnt_r <= blkCnt_r + 8'd1;
      end
      blockStartOut <= blkNxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking

  sequence s_eval_event;
    evalNow && enabled_r && !isMaster && primed_r && !holdoff_r && slipEvent;
  endsequence

  sequence s_second_x;
    preambleX && blkSeen_r && blkCnt_r == BLK_START_FIRST - 8'd1;
  endsequence

  a_reset_quiet: assert property (sys_rst |=> !serialDataOut && !outputFrameClockOe
                                  && !serialDataOutOe)
    else $error("outputs not quiet during reset");

  a_run_gate: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(enabled_r) |-> $past(ctrl1_r[RUN_BIT] && pllLocked))
    else $error("output enabled without run and lock");

  a_strap_capture: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == ST_STRAP |=> hardwareMode != $past(sdSense) ##1 serialDataOutOe)
    else $error("strap not latched before driving");

  a_mute_zero: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl1_r[MUTE_BIT] |=> !serialDataOut)
    else $error("data not muted");

  a_slip_set: assert property (@(posedge clk) disable iff (sys_rst)
    s_eval_event |=> slip_r)
    else $error("slip or repeat not flagged");

  a_slip_keep: assert property (@(posedge clk) disable iff (sys_rst)
    evalNow && edgeCnt_r == 2'd1 && !rdClear |=> slip_r == $past(slip_r))
    else $error("flag changed without event");

  a_slip_clear: assert property (@(posedge clk) disable iff (sys_rst)
    rdClear && !slipSet ##1 !slipSet [*2] |-> !slip_r)
    else $error("read did not clear flag");

  a_slave_inputs: assert property (@(posedge clk) disable iff (sys_rst)
    !isMaster [*2] |-> !outputFrameClockOe && !outputBitClockOe)
    else $error("slave mode drives clocks");

  a_frame_period: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(outputFrameClockOut) && enabled_r && isMaster && $stable(fmt_r)
    |-> ##256 ($rose(outputFrameClockOut) || !enabled_r || !isMaster || $changed(fmt_r)))
    else $error("frame clock period wrong");

  a_block_rise: assert property (@(posedge clk) disable iff (sys_rst)
    s_second_x |=> ##1 blockStartOut)
    else $error("block start late");

  a_no_rj_slave: assert property (@(posedge clk) disable iff (sys_rst)
    !isMaster |-> !rjEff)
    else $error("right justify in slave mode");

endmodule

// ==== sim/audio_sink_model.sv ====
module audio_sink_model (
  input  wire logic       clk,
  input  wire logic       slaveEn,
  input  wire logic [8:0] framePeriod,
  input  wire logic       framePin,
  input  wire logic       bitPin,
  input  wire logic       dataPin,
  output logic            frameDrv,
  output logic            bitDrv,
  output logic [23:0]     leftWord,
  output logic [8:0]      lastPeriod
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0]  cnt = 9'h000;
  logic [8:0]  since = 9'h000;
  logic [4:0]  nBits = 5'h00;
  logic [23:0] shift = 24'h000000;
  logic        framePrev = 1'b0;
  logic        bitPrev = 1'b0;
  initial frameDrv = 1'b0;
  initial bitDrv = 1'b0;
  initial leftWord = 24'h000000;
  initial lastPeriod = 9'h000;
  // Free-running frame clock at half duty, so each phase holds every data bit
  // Released clock lines toggle, so a stale level is never mistaken for a drive
  always @(posedge clk) begin
    cnt <= (cnt + 9'h001 >= framePeriod) ? 9'h000 : cnt + 9'h001;
    frameDrv <= slaveEn ? (cnt < {1'b0, framePeriod[8:1]}) : ~frameDrv;
    bitDrv <= slaveEn ? cnt[1] : ~bitDrv;
  end
  // Bits taken at rising bit clock, word closed at frame fall
  always @(posedge clk) begin
    framePrev <= framePin;
    bitPrev <= bitPin;
    since <= (framePin && !framePrev) ? 9'h001 : since + 9'h001;
    if (framePin && !framePrev) begin
      lastPeriod <= since;
      nBits <= 5'h00;
    end else if (bitPin && !bitPrev && nBits < 5'd24) begin
      shift <= {shift[22:0], dataPin};
      nBits <= nBits + 5'h01;
    end
    if (!framePin && framePrev)
      leftWord <= shift;
  end
endmodule

// ==== sim/tb.sv ====
module tb
  import serial_audio_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ID_V  = 4'h9;  // Arbitrary value
  localparam logic [3:0] REV_V = 4'h3;  // Arbitrary value
  typedef struct packed {
    logic [6:0] addr;
    logic       wr;
    logic [7:0] wd;
    logic [7:0] expd;
  } row_t;
  row_t         rows [14];
  logic         clk = 1'b0, sys_rst = 1'b1, pllLocked = 1'b1, preambleZ = 1'b0;
  logic         preambleX = 1'b0, inValid = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
  logic         slaveEn = 1'b0, genOn = 1'b0;
  logic [6:0]   regAddr = 7'h00;
  logic [7:0]   regWrData = 8'h00, gCnt = 8'h00, frm = 8'h00;
  logic [8:0]   framePeriod = 9'd256;
  audio_frame_t inFrame = '0;
  logic         inReady, fOut, fOe, bOut, bOe, dOut, dOe, gOut, gOe;
  logic         blockStartOut, hardwareMode, addrStrapBit, frameDrv, bitDrv;
  logic         framePin, bitPin, dataSense, gpoSense;
  logic [7:0]   regRdData;
  logic [23:0]  leftWord;
  logic [8:0]   lastPeriod;
  int           n_errors = 0, samples_checked = 0;
  assign framePin = fOe ? fOut : frameDrv;
  assign bitPin = bOe ? bOut : bitDrv;
  assign dataSense = dOe ? dOut : 1'b1;  // Pull-up selects software mode
  assign gpoSense = gOe ? gOut : 1'b1;  // Pull-up sets address bit
  serial_audio_output_port #(.FIFO_DEPTH(32), .PART_ID(ID_V), .REVISION(REV_V))
    serial_audio_output_port_inst (
    .clk(clk), .sys_rst(sys_rst), .pllLocked(pllLocked), .preambleZ(preambleZ),
    .preambleX(preambleX), .inValid(inValid), .inReady(inReady), .inFrame(inFrame),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .outputFrameClockIn(framePin), .outputFrameClockOut(fOut),
    .outputFrameClockOe(fOe), .outputBitClockIn(bitPin), .outputBitClockOut(bOut),
    .outputBitClockOe(bOe), .serialDataOutSense(dataSense), .serialDataOut(dOut),
    .serialDataOutOe(dOe), .generalOutTwoSense(gpoSense), .generalOutTwo(gOut),
    .generalOutTwoOe(gOe), .blockStartOut(blockStartOut), .hardwareMode(hardwareMode),
    .addrStrapBit(addrStrapBit));
  audio_sink_model audio_sink_model_inst (
    .clk(clk), .slaveEn(slaveEn), .framePeriod(framePeriod), .framePin(framePin),
    .bitPin(bitPin), .dataPin(dataSense), .frameDrv(frameDrv), .bitDrv(bitDrv),
    .leftWord(leftWord), .lastPeriod(lastPeriod));
  initial begin
    forever #2 clk = ~clk;
  end
  // One preamble every 256 clocks, Z opening each 192-frame block
  always @(negedge clk) begin
    preambleZ <= 1'b0;
    preambleX <= 1'b0;
    if (genOn) begin
      gCnt <= gCnt + 8'h01;
      if (gCnt == 8'h00) begin
        preambleZ <= (frm == 8'd0);
        preambleX <= (frm != 8'd0);
        frm <= (frm == 8'd191) ? 8'd0 : frm + 8'd1;
      end
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] expd);
    samples_checked = samples_checked + 1;
    if (got !== expd) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, expd);
    end
  endtask
  task automatic regWr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask
  task automatic regRd(input logic [6:0] a, output logic [7:0] q);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    q = regRdData;
  endtask
  // Waits mid-way into the frame opened by preamble number k
  task automatic atFrame(input logic [7:0] k);
    int t;
    t = 0;
    while (frm != k + 8'd1 && t < 60000) begin
      @(negedge clk);
      t = t + 1;
    end
    if (t >= 60000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
    repeat (128) @(negedge clk);
  endtask
  initial begin
    logic [7:0] q;
    int         n;
    rows[0] = '{7'h01, 1'b0, 8'h00, 8'h00};
    rows[1] = '{7'h03, 1'b0, 8'h00, 8'h00};
    rows[2] = '{7'h0d, 1'b0, 8'h00, 8'h00};
    rows[3] = '{7'h0e, 1'b0, 8'h00, 8'h01};
    rows[4] = '{7'h7f, 1'b0, 8'h00, {ID_V, REV_V}};
    rows[5] = '{7'h20, 1'b0, 8'h00, 8'h00};
    rows[6] = '{7'h20, 1'b1, 8'h5a, 8'h00};
    rows[7] = '{7'h7f, 1'b1, 8'hff, {ID_V, REV_V}};
    rows[8] = '{7'h03, 1'b1, 8'h85, 8'h85};
    rows[9] = '{7'h03, 1'b1, 8'h88, 8'h88};
    rows[10] = '{7'h03, 1'b1, 8'h30, 8'h30};
    rows[11] = '{7'h03, 1'b1, 8'h00, 8'h00};
    rows[12] = '{7'h01, 1'b1, 8'h04, 8'h04};
    rows[13] = '{7'h0e, 1'b1, 8'hff, 8'h01};
    inFrame.left = 24'ha5c3e1;
    inFrame.right = 24'h3c5a96;
    repeat (12) @(negedge clk);
    chk(dOe, 1'b0);
    chk(fOe, 1'b0);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(hardwareMode, 1'b0);
    chk(addrStrapBit, 1'b1);
    chk(dOe, 1'b1);
    $display("test reset done");
    foreach (rows[i]) begin
      if (rows[i].wr)
        regWr(rows[i].addr, rows[i].wd);
      regRd(rows[i].addr, q);
      chk(q, rows[i].expd);
    end
    $display("test registers done");
    n = 0;
    repeat (40) begin
      @(negedge clk);
      inValid = 1'b1;
      if (inReady === 1'b1)
        n = n + 1;
    end
    @(negedge clk);
    inValid = 1'b0;
    chk(24'(n), 24'd32);
    regWr(FORMAT_OFS, 8'h80);
    regWr(CTRL1_OFS, 8'h02);
    repeat (36 * 256) @(negedge clk);
    chk(leftWord, 24'ha5c3e1);
    chk(lastPeriod, 9'd256);
    chk(fOe, 1'b1);
    chk(inReady, 1'b1);
    regWr(CTRL1_OFS, 8'h03);
    repeat (512) @(negedge clk);
    chk(leftWord, 24'h000000);
    chk(lastPeriod, 9'd256);
    regWr(CTRL1_OFS, 8'h02);
    regWr(FORMAT_OFS, 8'h88);
    repeat (512) @(negedge clk);
    // Right-justified: the first 24 slots hold 8 idle bits, then the MSBs
    chk(leftWord, 24'h00a5c3);
    regWr(FORMAT_OFS, 8'hb0);
    repeat (512) @(negedge clk);
    chk(leftWord, 24'ha5c3e1);
    $display("test master done");
    regWr(FORMAT_OFS, 8'h00);
    regWr(CTRL1_OFS, 8'h06);
    slaveEn = 1'b1;
    genOn = 1'b1;
    atFrame(8'd1);
    chk(blockStartOut, 1'b0);
    atFrame(8'd2);
    chk(blockStartOut, 1'b1);
    chk(gOut, 1'b1);
    atFrame(8'd17);
    chk(blockStartOut, 1'b1);
    atFrame(8'd18);
    chk(blockStartOut, 1'b0);
    chk(gOut, 1'b0);
    atFrame(8'd20);
    regRd(INT1_STATUS_OFS, q);
    atFrame(8'd30);
    regRd(INT1_STATUS_OFS, q);
    chk(q, 8'h00);
    framePeriod = 9'd240;
    atFrame(8'd70);
    regRd(INT1_STATUS_OFS, q);
    chk(q, 8'h20);
    framePeriod = 9'd256;
    atFrame(8'd72);
    regRd(INT1_STATUS_OFS, q);
    atFrame(8'd80);
    regRd(INT1_STATUS_OFS, q);
    chk(q, 8'h00);
    framePeriod = 9'd280;
    atFrame(8'd100);
    regRd(INT1_STATUS_OFS, q);
    chk(q, 8'h20);
    $display("test slave done");
    finish_test();
  end
endmodule
